// file: verilog/prmc_top.sv
`timescale 1ns/1ps
`include "prmc_map.svh"

module prmc_top #(
  parameter int       NUM_PART         = 16,
  parameter bit       PARAM_AT_TOP     = 1'b1,
  parameter bit [15:0] MAKER_CODE      = 16'h00A5, // arbitrary value
  parameter bit [15:0] PART_CODE_TOP   = 16'h1234, // arbitrary value
  parameter bit [15:0] PART_CODE_BOTTOM = 16'h1235 // arbitrary value
) (
  // clock and reset
  input  wire logic                                  CLK_SYS,
  input  wire logic                                  NRST,
  // host bus pins
  input  wire logic                                  CE_N,
  input  wire logic                                  OE_N,
  input  wire logic                                  WE_N,
  input  wire logic [`PRMC_ADDR_W-1:0]               ADDR,
  input  wire logic [`PRMC_DATA_W-1:0]               DQ_IN,
  output logic      [`PRMC_DATA_W-1:0]               DQ_OUT,
  output logic                                       DQ_OE,
  // array core and parameter database
  output logic      [`PRMC_ADDR_W-1:0]               ARRAY_ADDR,
  input  wire logic [`PRMC_DATA_W-1:0]               ARRAY_DATA,
  input  wire logic [7:0]                            QUERY_DATA,
  // write state machine state
  input  wire logic                                  DEVICE_READY,
  input  wire logic [NUM_PART-1:0]                   PART_BUSY,
  input  wire prmc_pkg::prmc_flags_type [NUM_PART-1:0] PART_FLAGS,
  // lock, configuration and protection contents
  input  wire logic [1:0]                            BLOCK_LOCK,
  input  wire logic [`PRMC_DATA_W-1:0]               CONFIG_WORD,
  input  wire logic [`PRMC_DATA_W-1:0]               OTP_LOCK_WORD,
  input  wire logic [127:0]                          OTP_WORDS
);

  localparam int PW = $clog2(NUM_PART);

  initial begin
    if (NUM_PART < 2 || (1 << PW) != NUM_PART || `PRMC_PART_AW + PW > `PRMC_ADDR_W)
      $error("prmc_top: NUM_PART must be a power of two that fits the address");
  end

  // command decode: {sets mode, opens two-cycle sequence, mode}
  function automatic logic [3:0] cmd_decode(input logic [7:0] code);
    case (code)
      `PRMC_CMD_ARRAY:    cmd_decode = {2'b10, prmc_pkg::MODE_ARRAY};
      `PRMC_CMD_IDENT:    cmd_decode = {2'b10, prmc_pkg::MODE_IDENT};
      `PRMC_CMD_QUERY:    cmd_decode = {2'b10, prmc_pkg::MODE_QUERY};
      `PRMC_CMD_STATUS:   cmd_decode = {2'b10, prmc_pkg::MODE_STATUS};
      `PRMC_CMD_ERASE,
      `PRMC_CMD_PROG,
      `PRMC_CMD_PROG_ALT,
      `PRMC_CMD_EFP,
      `PRMC_CMD_LOCK_CFG,
      `PRMC_CMD_OTP_PROG: cmd_decode = {2'b11, prmc_pkg::MODE_STATUS};
      default:            cmd_decode = 4'h0; // clear, suspend, resume: modes kept
    endcase
  endfunction : cmd_decode

  // pin synchroniser: stage one feeds stage two only
  prmc_pkg::prmc_pins_type pin_s1;
  prmc_pkg::prmc_pins_type pin_s2;
  prmc_pkg::prmc_pins_type pin_s3;
  prmc_pkg::prmc_pins_type pin;
  wire prmc_pkg::prmc_pins_type pin_raw = {ADDR, DQ_IN, CE_N, OE_N, WE_N};

  // a bit moves only once stages two and three agree, so one-cycle glitches die
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pin_s1 <= '{default: '1};
      pin_s2 <= '{default: '1};
      pin_s3 <= '{default: '1};
      pin    <= '{default: '1};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin    <= (pin_s2 & pin_s3) | (pin & (pin_s2 ^ pin_s3));
    end
  end

  // previous strobe levels for edge detection
  logic ce_q;
  logic oe_q;
  logic we_q;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
    end else begin
      ce_q <= pin.ce_n;
      oe_q <= pin.oe_n;
      we_q <= pin.we_n;
    end
  end

  // write is taken on the rising edge of the write strobe with chip enable low
  wire          wr_take  = pin.we_n & ~we_q & ~ce_q;
  wire [PW-1:0] wr_part  = pin.addr[`PRMC_PART_AW +: PW];
  wire [7:0]    wr_code  = pin.data[7:0];
  wire [3:0]    wr_dec   = cmd_decode(wr_code);

  // second cycle of a two-cycle sequence is data, never a new command
  logic seq_open;
  logic seq_cfg;

  wire first_wr  = wr_take & ~seq_open;
  wire second_wr = wr_take & seq_open;
  wire cfg_done  = second_wr & seq_cfg & (wr_code == `PRMC_CMD_SET_CFG);

  // a set-configuration confirm returns the partition to array reads
  wire                    mode_we  = (first_wr & wr_dec[3]) | cfg_done;
  wire prmc_pkg::prmc_mode_type mode_val =
    cfg_done ? prmc_pkg::MODE_ARRAY : prmc_pkg::prmc_mode_type'(wr_dec[1:0]);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      seq_open <= 1'b0;
      seq_cfg  <= 1'b0;
    end else if (wr_take) begin
      seq_open <= first_wr & wr_dec[2];
      seq_cfg  <= first_wr & (wr_code == `PRMC_CMD_LOCK_CFG);
    end
  end

  // per-partition read mode
  prmc_pkg::prmc_mode_type mode [NUM_PART];

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_PART; i++) begin
        mode[i] <= prmc_pkg::MODE_ARRAY;
      end
    end else if (mode_we) begin
      // only the addressed partition moves
      // mode persists until the next read-mode, setup or set-configuration confirm command
      // busy partitions switch at once
      mode[wr_part] <= mode_val;
    end
  end

  // read side works on the address presented to the array core
  logic [`PRMC_ADDR_W-1:0] arr_addr;

  wire [PW-1:0]  rd_part  = arr_addr[`PRMC_PART_AW +: PW];
  wire [7:0]     rd_off   = arr_addr[7:0];
  wire           part_rel = (arr_addr[`PRMC_PART_AW-1:8] == '0);
  wire           blk_rel  = (arr_addr[11:8] == 4'h0);
  wire           rd_busy  = PART_BUSY[rd_part];
  wire prmc_pkg::prmc_mode_type rd_mode = mode[rd_part];
  wire [2:0]     otp_idx  = 3'(rd_off - `PRMC_OFF_OTP_FIRST);
  wire           otp_hit  = part_rel & (rd_off >= `PRMC_OFF_OTP_FIRST) &
                            (rd_off <= `PRMC_OFF_OTP_LAST);

  // identifier space word; unmapped offsets read zero
  wire [15:0] part_code = PARAM_AT_TOP ? PART_CODE_TOP : PART_CODE_BOTTOM;
  wire [15:0] lock_word = {14'h0000, BLOCK_LOCK[`PRMC_LOCKDOWN_BIT],
                           BLOCK_LOCK[`PRMC_LOCK_BIT]};
  wire [15:0] ident_word =
    (part_rel & rd_off == `PRMC_OFF_MAKER)    ? MAKER_CODE    :
    (part_rel & rd_off == `PRMC_OFF_PART)     ? part_code     :
    (blk_rel  & rd_off == `PRMC_OFF_LOCK)     ? lock_word     :
    (part_rel & rd_off == `PRMC_OFF_CONFIG)   ? CONFIG_WORD   :
    (part_rel & rd_off == `PRMC_OFF_OTP_LOCK) ? OTP_LOCK_WORD :
    otp_hit ? OTP_WORDS[16*otp_idx +: 16] : 16'h0000;

  // status word: bits 6..1 zero while the device is busy
  wire prmc_pkg::prmc_flags_type rd_flags = PART_FLAGS[rd_part];
  wire [5:0] flag_bits = DEVICE_READY ? rd_flags : 6'h00;
  wire       own_bit   = ~DEVICE_READY & ~rd_busy;
  wire [7:0] status_word = {DEVICE_READY, flag_bits, own_bit};

  // data for the non-status modes
  wire [15:0] array_word = rd_busy ? `PRMC_INVALID_WORD : ARRAY_DATA;
  wire [15:0] mode_word =
    (rd_mode == prmc_pkg::MODE_IDENT) ? ident_word :
    (rd_mode == prmc_pkg::MODE_QUERY) ? {8'h00, QUERY_DATA} :
    array_word;

  // read strobes: capture status on the first enable to fall
  wire rd_act   = ~pin.ce_n & ~pin.oe_n;
  wire cap_stat = ce_q & oe_q & (~pin.ce_n | ~pin.oe_n);

  logic [7:0] status_snap;

  // first word of a status read must already be fresh, so bypass the snapshot then
  wire [7:0] status_now = cap_stat ? status_word : status_snap;

  // single-read snapshot only; bursts into status mode see a frozen word
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      status_snap <= `PRMC_STATUS_RESET;
    end else if (cap_stat) begin
      status_snap <= status_word;
    end
  end

  // output registers
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      arr_addr <= '0;
      DQ_OUT   <= '0;
      DQ_OE    <= 1'b0;
    end else begin
      arr_addr <= pin.addr;
      DQ_OE    <= rd_act;
      if (!rd_act) begin
        DQ_OUT <= '0;
      end else if (rd_mode == prmc_pkg::MODE_STATUS) begin
        DQ_OUT <= {8'h00, status_now};
      end else begin
        DQ_OUT <= mode_word;
      end
    end
  end

  assign ARRAY_ADDR = arr_addr;

endmodule : prmc_top

// file: verilog/prmc_map.svh
`ifndef PRMC_MAP_SVH
`define PRMC_MAP_SVH

// host bus widths
`define PRMC_ADDR_W        22
`define PRMC_DATA_W        16
`define PRMC_PART_AW       18

// command codes on the low data byte
`define PRMC_CMD_ARRAY     8'hFF
`define PRMC_CMD_IDENT     8'h90
`define PRMC_CMD_QUERY     8'h98
`define PRMC_CMD_STATUS    8'h70
`define PRMC_CMD_CLR_STAT  8'h50
`define PRMC_CMD_ERASE     8'h20
`define PRMC_CMD_PROG      8'h40
`define PRMC_CMD_PROG_ALT  8'h10
`define PRMC_CMD_EFP       8'h30
`define PRMC_CMD_LOCK_CFG  8'h60
`define PRMC_CMD_OTP_PROG  8'hC0
`define PRMC_CMD_SUSPEND   8'hB0
`define PRMC_CMD_RESUME    8'hD0
`define PRMC_CMD_SET_CFG   8'h03

// identifier space offsets
`define PRMC_OFF_MAKER     8'h00
`define PRMC_OFF_PART      8'h01
`define PRMC_OFF_LOCK      8'h02
`define PRMC_OFF_CONFIG    8'h05
`define PRMC_OFF_OTP_LOCK  8'h80
`define PRMC_OFF_OTP_FIRST 8'h81
`define PRMC_OFF_OTP_LAST  8'h88

// block lock bit positions in the lock word
`define PRMC_LOCK_BIT      0
`define PRMC_LOCKDOWN_BIT  1

// word driven while a busy partition is read in array mode
`define PRMC_INVALID_WORD  16'hFFFF
// status register reset value
`define PRMC_STATUS_RESET  8'h00

`endif

// file: verilog/prmc_pkg.sv
`include "prmc_map.svh"

package prmc_pkg;

  // read mode of one partition
  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_IDENT  = 2'b01,
    MODE_QUERY  = 2'b10,
    MODE_STATUS = 2'b11
  } prmc_mode_type;

  // host pins after synchronisation
  typedef struct packed {
    logic [`PRMC_ADDR_W-1:0] addr;
    logic [`PRMC_DATA_W-1:0] data;
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
  } prmc_pins_type;

  // per-partition status flags from the write state machine
  typedef struct packed {
    logic erase_suspended_flag;
    logic erase_error_flag;
    logic program_error_flag;
    logic prog_voltage_fault_flag;
    logic program_suspended_flag;
    logic locked_block_abort_flag;
  } prmc_flags_type;

endpackage : prmc_pkg

// file: tb/prmc_top_sva.sv
`timescale 1ns/1ps
module prmc_sva #(
  parameter int NUM_PART = 16
) (
  // clock, reset and host pins
  input wire logic                CLK_SYS,
  input wire logic                NRST,
  input wire logic                CE_N,
  input wire logic                OE_N,
  input wire logic                WE_N,
  input wire logic [21:0]         ADDR,
  input wire logic [15:0]         DQ_IN,
  input wire logic [15:0]         DQ_OUT,
  input wire logic                DQ_OE,
  // core side
  input wire logic [21:0]         ARRAY_ADDR,
  input wire logic [15:0]         ARRAY_DATA,
  input wire logic [7:0]          QUERY_DATA,
  input wire logic [NUM_PART-1:0] PART_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // mode per partition as the host set it; leads the design by the sync delay
  logic [1:0] pm [16];
  logic       we_q;
  logic       sq;
  logic       sc;
  wire  [3:0] wp  = ADDR[21:18];
  wire  [1:0] cur = pm[ARRAY_ADDR[21:18]];
  wire        bsy = PART_BUSY[ARRAY_ADDR[21:18]];
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      we_q <= 1'b1;
      sq   <= 1'b0;
      sc   <= 1'b0;
      for (int i = 0; i < 16; i++) pm[i] <= 2'h0;
    end else begin
      we_q <= WE_N;
      if (WE_N && !we_q && !CE_N) begin
        sq <= 1'b0;
        sc <= !sq && DQ_IN[7:0] == 8'h60;
        if (sq) begin
          if (sc && DQ_IN[7:0] == 8'h03) pm[wp] <= 2'h0;
        end else begin
          case (DQ_IN[7:0])
            8'hFF: pm[wp] <= 2'h0;
            8'h90: pm[wp] <= 2'h1;
            8'h98: pm[wp] <= 2'h2;
            8'h70: pm[wp] <= 2'h3;
            8'h20, 8'h40, 8'h10, 8'h30, 8'h60, 8'hC0: begin
              pm[wp] <= 2'h3;
              sq     <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end
  rd_start_a: assert property ($rose(DQ_OE) |-> !$past(CE_N, 3) && !$past(OE_N, 3))
    else $error("data driven without a read");
  rd_stop_a: assert property ($rose(OE_N) |-> ##[2:5] !DQ_OE)
    else $error("data not released");
  addr_follow_a: assert property ($stable(ADDR)[*8] |-> ARRAY_ADDR == ADDR)
    else $error("core address lags");
  arr_data_a: assert property (DQ_OE && cur == 2'h0 && !bsy && $stable(ARRAY_ADDR)
    |-> DQ_OUT == ARRAY_DATA)
    else $error("array word wrong");
  arr_busy_a: assert property (DQ_OE && cur == 2'h0 && bsy |-> DQ_OUT == 16'hFFFF)
    else $error("busy read not invalid");
  query_a: assert property (DQ_OE && cur == 2'h2 && $stable(ARRAY_ADDR)
    |-> DQ_OUT == {8'h00, QUERY_DATA})
    else $error("query byte wrong");
  stat_upper_a: assert property (DQ_OE && cur == 2'h3 |-> DQ_OUT[15:8] == 8'h00)
    else $error("status upper byte set");
  stat_hold_a: assert property (DQ_OE && $past(DQ_OE) && cur == 2'h3 |-> $stable(DQ_OUT))
    else $error("status moved in read");
endmodule : prmc_sva

bind prmc_top prmc_sva #(.NUM_PART(NUM_PART)) u_sva (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .ADDR(ADDR), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
  .DQ_OE(DQ_OE), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA),
  .QUERY_DATA(QUERY_DATA), .PART_BUSY(PART_BUSY));

// file: tb/prmc_host.sv
`timescale 1ns/1ps
module prmc_host (
  // clock
  input  wire logic        CLK_SYS,
  // bus to the device
  output logic             CE_N,
  output logic             OE_N,
  output logic             WE_N,
  output logic      [21:0] ADDR,
  output logic      [15:0] DQ_IN,
  input  wire logic [15:0] DQ_OUT,
  input  wire logic        DQ_OE
);
  // idle bus
  initial begin
    CE_N  = 1'b1;
    OE_N  = 1'b1;
    WE_N  = 1'b1;
    ADDR  = 22'h000000;
    DQ_IN = 16'h0000;
  end
  // wait n clocks, then step off the edge
  task automatic idle(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : idle
  // strobes held 4 clocks so the pin filter accepts them
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    ADDR  = a;
    DQ_IN = d;
    CE_N  = 1'b0;
    idle(4);
    WE_N  = 1'b0;
    idle(4);
    WE_N  = 1'b1; // command with its target address
    idle(2);
    CE_N  = 1'b1;
    DQ_IN = ~d; // released lines do not keep the old value
    idle(8);
  endtask : wr
  // one single read, never a burst
  task automatic rd(input logic [21:0] a, output logic [15:0] d, output bit ok);
    int n;
    ADDR = a;
    idle(1);
    CE_N = 1'b0;
    OE_N = 1'b0;
    n    = 0;
    while (DQ_OE !== 1'b1 && n < 20) begin
      idle(1);
      n++;
    end
    ok = (n < 20);
    idle(2);
    d    = DQ_OUT;
    CE_N = 1'b1;
    OE_N = 1'b1;
    idle(8);
  endtask : rd
endmodule : prmc_host

// file: tb/prmc_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module prmc_top_tb;
  localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
  localparam logic [15:0] PCODE = 16'h4E21; // arbitrary value
  logic clk, nrst, rdy, ce_n, oe_n, we_n, dq_oe;
  logic [21:0] addr, arr_addr;
  logic [15:0] dq_in, dq_out, cfg, otp_lock, busy;
  logic [1:0] lock;
  logic [127:0] otp;
  prmc_pkg::prmc_flags_type [15:0] flags;
  int failures = 0;
  int checks   = 0;
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  prmc_top #(.MAKER_CODE(MAKER), .PART_CODE_TOP(PCODE)) dut (.CLK_SYS(clk), .NRST(nrst),
    .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .ARRAY_ADDR(arr_addr), .ARRAY_DATA(arr_addr[15:0] ^ 16'hA55A),
    .QUERY_DATA(arr_addr[7:0] ^ 8'h3C), .DEVICE_READY(rdy), .PART_BUSY(busy),
    .PART_FLAGS(flags), .BLOCK_LOCK(lock), .CONFIG_WORD(cfg), .OTP_LOCK_WORD(otp_lock),
    .OTP_WORDS(otp));
  prmc_host u_host (.CLK_SYS(clk), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  function automatic logic [21:0] pb(input logic [3:0] p);
    return {p, 18'h00000};
  endfunction : pb
  function automatic logic [15:0] ad(input logic [21:0] a);
    return a[15:0] ^ 16'hA55A;
  endfunction : ad
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // a hung read ends the run at once
  task automatic rchk(input string n, input logic [21:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    u_host.rd(a, d, ok);
    if (!ok) begin
      failures++;
      report_and_stop();
    end
    `CHK(n, e, d)
  endtask : rchk
  task automatic t_ident;
    logic [21:0] b;
    b = pb(4'h2);
    rchk("array", b + 22'h123, ad(b + 22'h123));
    u_host.wr(b, 16'h0090);
    rchk("maker", b, MAKER);
    rchk("part", b + 22'h1, PCODE);
    rchk("lock", b + 22'h2, {14'h0000, lock});
    rchk("config", b + 22'h5, cfg);
    rchk("otp lock", b + 22'h80, otp_lock);
    for (int i = 0; i < 8; i++) rchk("otp", b + 22'h81 + 22'(i), otp[16*i +: 16]);
    rchk("other", pb(4'h3) + 22'h1, ad(pb(4'h3) + 22'h1));
    rchk("kept", b + 22'h1, PCODE);
    u_host.wr(b, 16'h00FF);
    rchk("array back", b + 22'h1, ad(b + 22'h1));
    $display("t_ident done");
  endtask : t_ident
  task automatic t_query;
    busy[4] = 1'b1;
    u_host.wr(pb(4'h4), 16'h0098);
    rchk("query", pb(4'h4) + 22'h10, 16'h002C);
    busy[4] = 1'b0;
    $display("t_query done");
  endtask : t_query
  task automatic t_status;
    flags[5] = prmc_pkg::prmc_flags_type'(6'h2A);
    u_host.wr(pb(4'h5), 16'h0070);
    rchk("status ready", pb(4'h5), 16'h00D4);
    rdy     = 1'b0;
    busy[5] = 1'b1;
    rchk("status own", pb(4'h5), 16'h0000);
    busy    = 16'h0200;
    rchk("status other", pb(4'h5), 16'h0001);
    rdy  = 1'b1;
    busy = 16'h0040;
    u_host.wr(pb(4'h6), 16'h0040);
    u_host.wr(pb(4'h6), 16'h1234);
    rchk("status setup", pb(4'h6), 16'h0080);
    u_host.wr(pb(4'h6), 16'h00FF);
    rchk("busy array", pb(4'h6) + 22'h7, 16'hFFFF);
    busy = 16'h0000;
    rchk("done array", pb(4'h6) + 22'h7, ad(pb(4'h6) + 22'h7));
    $display("t_status done");
  endtask : t_status
  // busy partition modes, suspend, configuration sequence, clear keeps mode
  task automatic t_seq;
    busy = 16'h0100;
    u_host.wr(pb(4'h8), 16'h0090);
    rchk("busy ident", pb(4'h8), MAKER);
    u_host.wr(pb(4'h8), 16'h00FF);
    rchk("busy array8", pb(4'h8) + 22'h3, 16'hFFFF);
    u_host.wr(pb(4'h8), 16'h00B0);
    busy = 16'h0000;
    u_host.wr(pb(4'h8), 16'h00FF);
    rchk("suspend array", pb(4'h8) + 22'h3, ad(pb(4'h8) + 22'h3));
    u_host.wr(pb(4'h7), 16'h0060);
    rchk("cfg setup", pb(4'h7), 16'h0080);
    u_host.wr(pb(4'h7), 16'h0003);
    rchk("cfg done", pb(4'h7) + 22'h9, ad(pb(4'h7) + 22'h9));
    u_host.wr(pb(4'h9), 16'h0098);
    u_host.wr(pb(4'h9), 16'h0050);
    rchk("query kept", pb(4'h9) + 22'h21, 16'h001D);
    $display("t_seq done");
  endtask : t_seq
  // reset in mid-run returns a partition in identifier mode to array reads
  task automatic t_reset;
    u_host.wr(pb(4'h2), 16'h0090);
    nrst = 1'b0;
    u_host.idle(3);
    nrst = 1'b1;
    u_host.idle(2);
    rchk("reset array", pb(4'h2) + 22'h1, ad(pb(4'h2) + 22'h1));
    $display("t_reset done");
  endtask : t_reset
  // reset, then the scenarios
  initial begin
    nrst     = 1'b0;
    rdy      = 1'b1;
    busy     = 16'h0000;
    flags    = '0;
    lock     = 2'h2;
    cfg      = 16'h3C5A;
    otp_lock = 16'h0002;
    otp      = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    u_host.idle(2);
    t_ident();
    t_query();
    t_status();
    t_seq();
    t_reset();
    report_and_stop();
  end
endmodule : prmc_top_tb
